//--- core/address_gen_unit.v
`include "agu_regs.vh"

module address_gen_unit #(
  parameter AW = `AGU_AW,
  parameter DW = `AGU_DW
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // global data bus access
  input wire gdb_wr_en,
  input wire gdb_rd_en,
  input wire [1:0] gdb_sel,
  input wire [2:0] gdb_idx,
  input wire [DW-1:0] global_data_bus_in,
  output reg [DW-1:0] global_data_bus_q,
  // low half update request
  input wire lo_upd_en,
  input wire [1:0] lo_upd_reg,
  input wire [2:0] lo_upd_op,
  // high half update request
  input wire hi_upd_en,
  input wire [1:0] hi_upd_reg,
  input wire [2:0] hi_upd_op,
  // address bus routing, src 0 = low half, 1 = high half
  input wire x_bus_en,
  input wire x_bus_src,
  input wire y_bus_en,
  input wire y_bus_src,
  input wire p_bus_en,
  input wire p_bus_src,
  // address buses
  output reg [AW-1:0] x_data_addr_bus_q,
  output reg [AW-1:0] y_data_addr_bus_q,
  output reg [AW-1:0] program_addr_bus_q
);

  ////////////////////////////////////////////////////////////////////////////

  reg [AW-1:0] pointer_reg_q [0:`AGU_NREG-1];
  reg [AW-1:0] step_offset_reg_q [0:`AGU_NREG-1];
  reg [AW-1:0] arith_modifier_reg_q [0:`AGU_NREG-1];

  integer i;

  // arithmetic kinds the modifier decode can pick
  localparam [1:0] KIND_LIN = 2'h0;
  localparam [1:0] KIND_RC = 2'h1;
  localparam [1:0] KIND_MOD = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [15:0] rev16;
    input [15:0] v;
    integer b;
    begin
      for (b = 0; b < 16; b = b + 1) begin
        rev16[b] = v[15-b];
      end
    end
  endfunction

  // smallest all-ones mask covering the modifier value
  function [15:0] fill_mask;
    input [15:0] v;
    reg [15:0] t;
    begin
      t = v;
      t = t | (t >> 1);
      t = t | (t >> 2);
      t = t | (t >> 4);
      t = t | (t >> 8);
      fill_mask = t;
    end
  endfunction

  function is_down;
    input [2:0] op;
    begin
      is_down = (op == `OP_POST_DEC) || (op == `OP_POST_SUBN) ||
        (op == `OP_PRE_DEC);
    end
  endfunction

  function uses_n;
    input [2:0] op;
    begin
      uses_n = (op == `OP_POST_ADDN) || (op == `OP_POST_SUBN) ||
        (op == `OP_INDEX_N);
    end
  endfunction

  // codes 8000..FFFE have no arithmetic of their own; they fall back to
  // linear so a stray modifier value never freezes a pointer
  function [1:0] arith_kind;
    input [15:0] m;
    begin
      if (m == `MOD_REVCARRY) begin
        arith_kind = KIND_RC;
      end else if (!m[`MOD_MODULO_BIT]) begin
        arith_kind = KIND_MOD;
      end else begin
        arith_kind = KIND_LIN;
      end
    end
  endfunction

  // one address ALU: offset, modulo and reverse-carry adders
  function [15:0] agu_calc;
    input [15:0] r;
    input [15:0] n;
    input [15:0] m;
    input [2:0] op;
    reg [15:0] mag;
    reg [15:0] step;
    reg [15:0] lin;
    reg [15:0] rc;
    reg [15:0] mask;
    reg [15:0] base;
    reg [16:0] top;
    reg [16:0] s17;
    reg [16:0] d17;
    reg [15:0] modres;
    begin
      mag = uses_n(op) ? n : 16'h0001;
      step = is_down(op) ? (~mag + 16'h0001) : mag;
      lin = r + step;
      rc = rev16(rev16(r) + rev16(step));
      mask = fill_mask(m);
      base = r & ~mask;
      top = {1'b0, base} + {1'b0, m};
      s17 = {1'b0, r} + {1'b0, mag};
      d17 = {1'b0, r} - {1'b0, mag};
      // wrap only when the offset sum leaves the buffer window
      if (is_down(op)) begin
        if (d17[16] || (d17[15:0] < base)) begin
          modres = d17[15:0] + m + 16'h0001;
        end else begin
          modres = lin;
        end
      end else begin
        if (s17 > top) begin
          modres = s17[15:0] - m - 16'h0001;
        end else begin
          modres = lin;
        end
      end
      // selection logic decoding the modifier
      case (arith_kind(m))
        KIND_RC: begin
          agu_calc = rc;
        end
        KIND_MOD: begin
          agu_calc = modres;
        end
        default: begin
          // linear, and the unassigned upper modifier codes
          agu_calc = lin;
        end
      endcase
    end
  endfunction

  function writes_back;
    input en;
    input [2:0] op;
    begin
      writes_back = en && (op != `OP_NONE) && (op != `OP_INDEX_N) &&
        (op <= `OP_PRE_DEC);
    end
  endfunction

  function ea_is_result;
    input [2:0] op;
    begin
      ea_is_result = (op == `OP_INDEX_N) || (op == `OP_PRE_DEC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-half address ALUs

  wire [2:0] lo_idx;
  wire [2:0] hi_idx;
  reg [AW-1:0] lo_res;
  reg [AW-1:0] hi_res;
  reg [AW-1:0] lo_ea;
  reg [AW-1:0] hi_ea;
  wire lo_wb;
  wire hi_wb;

  // low half owns triplets 0..3, high half 4..7
  assign lo_idx = {1'b0, lo_upd_reg};
  assign hi_idx = {1'b1, hi_upd_reg};

  always @* begin
    lo_res = agu_calc(pointer_reg_q[lo_idx], step_offset_reg_q[lo_idx],
      arith_modifier_reg_q[lo_idx], lo_upd_op);
    hi_res = agu_calc(pointer_reg_q[hi_idx], step_offset_reg_q[hi_idx],
      arith_modifier_reg_q[hi_idx], hi_upd_op);
    // post modes address with the old pointer
    lo_ea = ea_is_result(lo_upd_op) ? lo_res
      : pointer_reg_q[lo_idx];
    hi_ea = ea_is_result(hi_upd_op) ? hi_res
      : pointer_reg_q[hi_idx];
  end

  assign lo_wb = writes_back(lo_upd_en, lo_upd_op);
  assign hi_wb = writes_back(hi_upd_en, hi_upd_op);

  ////////////////////////////////////////////////////////////////////////////
  // register files

  always @(posedge mclk) begin
    if (reset) begin
      for (i = 0; i < `AGU_NREG; i = i + 1) begin
        pointer_reg_q[i] <= `PTR_RESET;
        step_offset_reg_q[i] <= `OFS_RESET;
        arith_modifier_reg_q[i] <= `MOD_RESET;
      end
    end else begin
      if (lo_wb) begin
        pointer_reg_q[lo_idx] <= lo_res;
      end
      if (hi_wb) begin
        pointer_reg_q[hi_idx] <= hi_res;
      end
      // a bus write lands after the updates, so it wins a collision
      if (gdb_wr_en) begin
        case (gdb_sel)
          `SEL_PTR: begin
            pointer_reg_q[gdb_idx] <= global_data_bus_in[15:0];
          end
          `SEL_OFS: begin
            step_offset_reg_q[gdb_idx] <=
              global_data_bus_in[15:0];
          end
          `SEL_MOD: begin
            arith_modifier_reg_q[gdb_idx] <=
              global_data_bus_in[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global data bus read

  always @(posedge mclk) begin
    if (reset) begin
      global_data_bus_q <= 24'h000000;
    end else if (gdb_rd_en) begin
      case (gdb_sel)
        `SEL_PTR: begin
          global_data_bus_q <=
            {8'h00, pointer_reg_q[gdb_idx]};
        end
        `SEL_OFS: begin
          global_data_bus_q <=
            {8'h00, step_offset_reg_q[gdb_idx]};
        end
        `SEL_MOD: begin
          global_data_bus_q <=
            {8'h00, arith_modifier_reg_q[gdb_idx]};
        end
        default: begin
          global_data_bus_q <= 24'h000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address output multiplexers; buses hold their last address when idle

  always @(posedge mclk) begin
    if (reset) begin
      x_data_addr_bus_q <= 16'h0000;
      y_data_addr_bus_q <= 16'h0000;
      program_addr_bus_q <= 16'h0000;
    end else begin
      if (x_bus_en) begin
        x_data_addr_bus_q <= x_bus_src ? hi_ea : lo_ea;
      end
      if (y_bus_en) begin
        y_data_addr_bus_q <= y_bus_src ? hi_ea : lo_ea;
      end
      if (p_bus_en) begin
        // full 16-bit space on every bus, no extra paging
        program_addr_bus_q <= p_bus_src ? hi_ea : lo_ea;
      end
    end
  end

  // both halves can feed two buses in the same cycle
  // keeping x and y on different halves is up to the instruction decode;
  // nothing here stops two buses from taking the same address

endmodule // address_gen_unit

//--- core/agu_regs.vh
`ifndef AGU_REGS_VH
`define AGU_REGS_VH

`define AGU_AW 16
`define AGU_DW 24
`define AGU_NREG 8

// register file select on the global data bus
`define SEL_PTR 2'h0
`define SEL_OFS 2'h1
`define SEL_MOD 2'h2

// reset values
`define MOD_RESET 16'hFFFF
`define PTR_RESET 16'h0000
`define OFS_RESET 16'h0000

// modifier decode
`define MOD_LINEAR 16'hFFFF
`define MOD_REVCARRY 16'h0000
`define MOD_MODULO_BIT 15

// update operations
`define OP_NONE 3'h0
`define OP_POST_INC 3'h1
`define OP_POST_DEC 3'h2
`define OP_POST_ADDN 3'h3
`define OP_POST_SUBN 3'h4
`define OP_INDEX_N 3'h5
`define OP_PRE_DEC 3'h6

`endif

//--- sim/agu_chk.sv
module agu_chk #(
  parameter AW = 16,
  parameter DW = 24
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // register bus
  input wire gdb_wr_en,
  input wire gdb_rd_en,
  input wire [1:0] gdb_sel,
  input wire [2:0] gdb_idx,
  input wire [DW-1:0] global_data_bus_in,
  input wire [DW-1:0] global_data_bus_q,
  // address side
  input wire [2:0] lo_upd_op,
  input wire x_bus_en,
  input wire x_bus_src,
  input wire y_bus_en,
  input wire y_bus_src,
  input wire [AW-1:0] x_data_addr_bus_q,
  input wire [AW-1:0] y_data_addr_bus_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  reg [15:0] wd_q;
  always @(posedge mclk) wd_q <= global_data_bus_in[15:0];
  //////////////////////////////////////////////////////////////////////////
  chk_top_zero: assert property (
    global_data_bus_q[DW-1:16] == 8'h00) else $error("top byte set");
  chk_read_hold: assert property (
    !$past(gdb_rd_en) && !$past(reset) |-> $stable(global_data_bus_q))
    else $error("read data moved");
  chk_unmapped_zero: assert property (
    gdb_rd_en && gdb_sel == 2'h3 |=> global_data_bus_q == 24'h000000)
    else $error("unmapped read not zero");
  chk_mod_reset: assert property (
    $fell(reset) && gdb_rd_en && gdb_sel == 2'h2
    |=> global_data_bus_q == 24'h00FFFF) else $error("modifier not preset");
  chk_write_read: assert property (
    gdb_wr_en && gdb_sel != 2'h3 ##1 gdb_rd_en && !gdb_wr_en &&
    gdb_sel == $past(gdb_sel) && gdb_idx == $past(gdb_idx)
    |=> global_data_bus_q[15:0] == $past(wd_q)) else $error("readback");
  chk_bus_hold: assert property (
    !$past(x_bus_en) && !$past(reset) |-> $stable(x_data_addr_bus_q))
    else $error("x bus moved");
  chk_same_src: assert property (
    x_bus_en && y_bus_en && x_bus_src == y_bus_src
    |=> x_data_addr_bus_q == y_data_addr_bus_q) else $error("bus mux");
  chk_post_reset_ea: assert property (
    $fell(reset) && x_bus_en && !x_bus_src |=> x_data_addr_bus_q ==
    ($past(lo_upd_op) == 3'h6 ? 16'hFFFF : 16'h0000)) else $error("ea");
  cover property (gdb_wr_en ##1 gdb_rd_en);
  cover property ($fell(reset) && x_bus_en);
  cover property (x_bus_en && y_bus_en && x_bus_src);
endmodule // agu_chk

bind address_gen_unit agu_chk #(.AW(AW), .DW(DW)) u_agu_chk (.mclk, .reset,
  .gdb_wr_en, .gdb_rd_en, .gdb_sel, .gdb_idx, .global_data_bus_in,
  .global_data_bus_q, .lo_upd_op, .x_bus_en, .x_bus_src, .y_bus_en,
  .y_bus_src, .x_data_addr_bus_q, .y_data_addr_bus_q);

//--- sim/addr_bus_sink.sv
module addr_bus_sink (
  // clock
  input wire mclk,
  // address bus as the x memory sees it; any 16-bit value is a location
  input wire [15:0] x_data_addr_bus_q,
  // count of address changes
  output int loads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] prev_q;
  int cnt = 0;
  assign loads = cnt;
  always @(posedge mclk) begin
    prev_q <= x_data_addr_bus_q;
    if (x_data_addr_bus_q != prev_q) cnt <= cnt + 1;
  end
endmodule // addr_bus_sink

//--- sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, gdb_wr_en, gdb_rd_en, lo_upd_en, hi_upd_en;
  logic x_bus_en, x_bus_src, y_bus_en, y_bus_src, p_bus_en, p_bus_src;
  logic [1:0] gdb_sel, lo_upd_reg, hi_upd_reg;
  logic [2:0] gdb_idx, lo_upd_op, hi_upd_op;
  logic [23:0] global_data_bus_in, v;
  wire [23:0] global_data_bus_q;
  wire [15:0] x_data_addr_bus_q, y_data_addr_bus_q, program_addr_bus_q;
  logic [31:0] rnd;
  logic [15:0] a, n, x_exp;
  int n_fail, checks_done, k, loads, x_loads;
  address_gen_unit u_address_gen_unit (.mclk, .reset, .gdb_wr_en,
    .gdb_rd_en, .gdb_sel, .gdb_idx, .global_data_bus_in,
    .global_data_bus_q, .lo_upd_en, .lo_upd_reg, .lo_upd_op, .hi_upd_en,
    .hi_upd_reg, .hi_upd_op, .x_bus_en, .x_bus_src, .y_bus_en, .y_bus_src,
    .p_bus_en, .p_bus_src, .x_data_addr_bus_q, .y_data_addr_bus_q,
    .program_addr_bus_q);
  addr_bus_sink u_addr_bus_sink (.mclk, .x_data_addr_bus_q, .loads);
  //////////////////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [23:0] rd_exp(input [1:0] s, input [23:0] d);
    rd_exp = (s == 2'h3) ? 24'h000000 : {8'h00, d[15:0]};
  endfunction
  task cmp(input string nm, input [47:0] seen, input [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // write strobe stays up so back-to-back writes never toggle in one step
  task wr(input [1:0] s, input [2:0] i, input [23:0] d);
    gdb_rd_en <= 1'b0;
    gdb_wr_en <= 1'b1;
    gdb_sel <= s;
    gdb_idx <= i;
    global_data_bus_in <= d;
    @(posedge mclk);
  endtask
  task rd(input [1:0] s, input [2:0] i);
    gdb_wr_en <= 1'b0;
    gdb_rd_en <= 1'b1;
    gdb_sel <= s;
    gdb_idx <= i;
    @(posedge mclk);
    gdb_rd_en <= 1'b0;
    #1 v = global_data_bus_q;
    @(posedge mclk);
  endtask
  // all three buses follow the chosen half
  task step(input h, input [1:0] r, input [2:0] op, input [15:0] e);
    gdb_wr_en <= 1'b0;
    {lo_upd_en, hi_upd_en} <= {!h, h};
    lo_upd_reg <= r;
    hi_upd_reg <= r;
    lo_upd_op <= h ? 3'h0 : op;
    hi_upd_op <= h ? op : 3'h0;
    {x_bus_en, y_bus_en, p_bus_en} <= 3'h7;
    {x_bus_src, y_bus_src, p_bus_src} <= {3{h}};
    @(posedge mclk);
    {x_bus_en, y_bus_en, p_bus_en, lo_upd_en, hi_upd_en} <= 5'h00;
    #1 cmp("buses", {x_data_addr_bus_q, y_data_addr_bus_q,
      program_addr_bus_q}, {3{e}});
    // the x memory should see one new address per change of ea
    if (e != x_exp) x_loads++;
    x_exp = e;
    @(posedge mclk);
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #50000;
    n_fail++;
    results;
  end
  initial begin
    {reset, gdb_wr_en, gdb_rd_en, lo_upd_en, hi_upd_en} = 5'h10;
    {x_bus_en, x_bus_src, y_bus_en, y_bus_src, p_bus_en, p_bus_src} = 6'h00;
    {gdb_sel, lo_upd_reg, hi_upd_reg, gdb_idx, lo_upd_op, hi_upd_op} = 0;
    global_data_bus_in = 24'h000000;
    n_fail = 0;
    checks_done = 0;
    rnd = 32'h5E6FD3DA;
    x_exp = 16'h0000;
    x_loads = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(2'h2, 3'h5);
    cmp("modifier", v, 24'h00FFFF);
    for (k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      wr(rnd[1:0], rnd[4:2], rnd[31:8]);
      rd(rnd[1:0], rnd[4:2]);
      cmp("register", v, rd_exp(rnd[1:0], rnd[31:8]));
    end
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      a = rnd[15:0];
      n = rnd[31:16];
      wr(2'h2, k[2:0], 24'h00FFFF);
      wr(2'h1, k[2:0], {8'hA5, n});
      wr(2'h0, k[2:0], {8'h5A, a});
      step(k[2], k[1:0], 3'h1, a);
      step(k[2], k[1:0], 3'h3, a + 16'h0001);
      step(k[2], k[1:0], 3'h4, a + 16'h0001 + n);
      step(k[2], k[1:0], 3'h2, a + 16'h0001);
      step(k[2], k[1:0], 3'h6, a - 16'h0001);
      step(k[2], k[1:0], 3'h5, a - 16'h0001 + n);
      step(k[2], k[1:0], 3'h0, a - 16'h0001);
    end
    // modulo 4 buffer spans 4..7
    wr(2'h2, 3'h2, 24'h000003);
    wr(2'h0, 3'h2, 24'h000007);
    step(1'b0, 2'h2, 3'h1, 16'h0007);
    step(1'b0, 2'h2, 3'h2, 16'h0004);
    step(1'b0, 2'h2, 3'h0, 16'h0007);
    // bit-reversed walk with offset 8000: 0, 8000, 4000
    wr(2'h2, 3'h6, 24'h000000);
    wr(2'h1, 3'h6, 24'h008000);
    wr(2'h0, 3'h6, 24'h000000);
    step(1'b1, 2'h2, 3'h3, 16'h0000);
    step(1'b1, 2'h2, 3'h3, 16'h8000);
    step(1'b1, 2'h2, 3'h0, 16'h4000);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    // reset drops the x bus back to zero
    if (x_exp != 16'h0000) x_loads++;
    x_exp = 16'h0000;
    step(1'b0, 2'h1, 3'h6, 16'hFFFF);
    #1 cmp("x loads", loads, x_loads);
    results;
  end
endmodule // tb
